// ### core/mps_pkg.sv
package mps_pkg;

    // ------------------------------------------------------------
    // microword layout
    // ------------------------------------------------------------
    localparam int MW_W = 16;
    localparam int PC_W = 8;
    localparam int DW = 8;
    localparam int FILE_AW = 4;
    localparam int FMT_HI = 15;
    localparam int FMT_LO = 12;
    localparam logic [PC_W-1:0] PC_RESET = 8'h00;

    // execute-format sub kinds in bits 11:10
    localparam logic [1:0] XK_INDEXED = 2'h0;
    localparam logic [1:0] XK_TRUNC4 = 2'h1;
    localparam logic [1:0] XK_TRUNC6 = 2'h2;
    localparam int TRUNC4_W = 4;
    localparam int TRUNC6_W = 6;

    // literal digits
    localparam logic [3:0] LD_FILE = 4'h1;
    localparam logic [3:0] LD_SRC = 4'h2;
    localparam logic [3:0] LD_FUNC = 4'h3;
    localparam logic [3:0] LD_INDEX = 4'h4;
    localparam logic [3:0] LD_ADD = 4'h5;
    localparam logic [3:0] LD_AND = 4'h6;
    localparam logic [3:0] LD_JUMP = 4'h7;

    // carry options, routing, source select
    localparam logic [1:0] CO_ZERO = 2'h0;
    localparam logic [1:0] CO_ONE = 2'h1;
    localparam logic [1:0] CO_FLAG = 2'h2;
    localparam logic [1:0] RT_NONE = 2'h0;
    localparam logic [1:0] RT_FUNC = 2'h1;
    localparam logic [1:0] RT_INDEX = 2'h2;
    localparam logic [1:0] RT_SRC = 2'h3;
    localparam logic [1:0] SS_SRC = 2'h0;
    localparam logic [1:0] SS_INDEX = 2'h1;
    localparam logic [1:0] SS_FUNC = 2'h2;

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CREGS = 8'h08;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b0;

    typedef enum logic [2:0] {
        MPS_FMT_EXEC = 3'b001,
        MPS_FMT_LIT = 3'b010,
        MPS_FMT_OPR = 3'b100
    } mps_fmt_t;

    typedef enum logic [1:0] {
        MPS_ST_FETCH = 2'b01,
        MPS_ST_RUN = 2'b10
    } mps_state_t;

    typedef struct packed {
        logic one;
        logic [2:0] op;
        logic [3:0] file;
        logic [1:0] src;
        logic [1:0] carry;
        logic [1:0] route;
        logic inhibit;
        logic spare;
    } mps_opr_t;

    typedef struct packed {
        logic [3:0] digit;
        logic [3:0] file;
        logic [7:0] emit;
    } mps_lit_t;

    typedef struct packed {
        logic c;
        logic v;
        logic g;
        logic l;
    } mps_flags_t;

endpackage

// ### core/mps_file_mem.sv
`timescale 1ns/100ps
module mps_file_mem
    import mps_pkg::*;
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [FILE_AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [FILE_AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:(1<<FILE_AW)-1];

    // no reset on the array: file contents are undefined until written
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        rdata_o <= mem[raddr_i];
    end

endmodule

// ### core/mps_sequencer.sv
// Operation
// - not taken branch: counter advances by one
// - jump loads next address from microword
// - global branch reaches all 256 locations
// - branch qualified by selected C V G L
// - truncated field replaces only low bits
// - six bit target stays in page
// - three bit field decoded one-hot
// - top digit 1 to 7 is literal
// - top digit 8 to f is operate
// - top digit zero is execute
// - literal: constant, combine, global jump
// - emit field driven out as constant
// - operate uses file and source registers
// - carry option can force carry in one
// - routing field picks control register destination
// - result goes to file and routed register
// - inhibit bit suppresses only file write
// - execute word indexed by index register
`timescale 1ns/100ps
module mps_sequencer
    import mps_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [PC_W-1:0] cs_addr_o,
    input wire logic [MW_W-1:0] cs_data_i,
    output logic [7:0] gate_o,
    output logic [DW-1:0] emit_o,
    output logic [DW-1:0] result_o,
    output logic [DW-1:0] func_o
);

    // ------------------------------------------------------------
    // decoders
    // ------------------------------------------------------------
    function automatic logic [7:0] onehot3(input logic [2:0] sel);
        onehot3 = 8'h01 << sel;
    endfunction

    function automatic mps_fmt_t fmt_of(input logic [3:0] digit);
        if (digit == 4'h0)
        begin
            fmt_of = MPS_FMT_EXEC;
        end
        else if (digit[3])
        begin
            fmt_of = MPS_FMT_OPR;
        end
        else
        begin
            fmt_of = MPS_FMT_LIT;
        end
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mps_state_t state;
    logic [PC_W-1:0] pc;
    logic [MW_W-1:0] ir;
    mps_fmt_t ir_fmt;
    mps_flags_t flags;
    logic [DW-1:0] src_reg;
    logic [DW-1:0] func_reg;
    logic [DW-1:0] index_reg;
    logic run;
    logic [DW-1:0] file_rdata;

    // ------------------------------------------------------------
    // fetch: expand indexed execute words before the file read
    // ------------------------------------------------------------
    logic [MW_W-1:0] fetched;
    mps_fmt_t fetched_fmt;
    logic [FILE_AW-1:0] file_raddr;

    always_comb
    begin
        fetched = cs_data_i;
        fetched_fmt = fmt_of(cs_data_i[FMT_HI:FMT_LO]);
        if (fetched_fmt == MPS_FMT_EXEC && cs_data_i[11:10] == XK_INDEXED)
        begin
            // index register picks the file register of the performed word
            fetched = {1'b1, cs_data_i[9:7], index_reg[FILE_AW-1:0],
                       cs_data_i[6:0], 1'b0};
            fetched_fmt = MPS_FMT_OPR;
        end
        file_raddr = fetched[11:8];
    end

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    mps_opr_t opw;
    mps_lit_t lw;
    logic [DW-1:0] opnd_b;
    logic cin;
    logic [DW:0] sum;
    logic [DW-1:0] alu_y;
    logic alu_c;
    logic alu_v;
    logic taken;
    logic [PC_W-1:0] next_pc;
    logic file_we;
    logic flags_we;

    always_comb
    begin
        opw = mps_opr_t'(ir);
        lw = mps_lit_t'(ir);
        case (opw.src)
            SS_SRC: opnd_b = src_reg;
            SS_INDEX: opnd_b = index_reg;
            SS_FUNC: opnd_b = func_reg;
            default: opnd_b = 8'h00;
        endcase
        case (opw.carry)
            CO_ONE: cin = 1'b1;
            CO_FLAG: cin = flags.c;
            default: cin = 1'b0;
        endcase
        if (ir_fmt == MPS_FMT_LIT)
        begin
            // literal combine ops use the emit field as second operand
            opnd_b = lw.emit;
            cin = 1'b0;
        end
        sum = 9'h000;
        alu_y = 8'h00;
        alu_c = 1'b0;
        alu_v = 1'b0;
        if (ir_fmt == MPS_FMT_LIT && lw.digit == LD_AND)
        begin
            alu_y = file_rdata & opnd_b;
        end
        else if (ir_fmt == MPS_FMT_LIT)
        begin
            sum = {1'b0, file_rdata} + {1'b0, opnd_b};
            alu_y = sum[DW-1:0];
            alu_c = sum[DW];
            alu_v = (file_rdata[7] == opnd_b[7]) && (alu_y[7] != file_rdata[7]);
        end
        else
        begin
            case (opw.op)
                3'h0:
                begin
                    sum = {1'b0, file_rdata} + {1'b0, opnd_b} + {8'h00, cin};
                    alu_y = sum[DW-1:0];
                    alu_c = sum[DW];
                    alu_v = (file_rdata[7] == opnd_b[7]) && (alu_y[7] != file_rdata[7]);
                end
                3'h1:
                begin
                    sum = {1'b0, file_rdata} + {1'b0, ~opnd_b} + {8'h00, cin};
                    alu_y = sum[DW-1:0];
                    alu_c = sum[DW];
                    alu_v = (file_rdata[7] != opnd_b[7]) && (alu_y[7] != file_rdata[7]);
                end
                3'h2: alu_y = file_rdata & opnd_b;
                3'h3: alu_y = file_rdata | opnd_b;
                3'h4: alu_y = file_rdata ^ opnd_b;
                3'h5: alu_y = opnd_b;
                3'h6:
                begin
                    alu_y = {file_rdata[6:0], cin};
                    alu_c = file_rdata[7];
                end
                default:
                begin
                    alu_y = {cin, file_rdata[7:1]};
                    alu_c = file_rdata[0];
                end
            endcase
        end
    end

    // next address selection
    always_comb
    begin
        taken = 1'b0;
        next_pc = pc + 8'h01;
        if (ir_fmt == MPS_FMT_LIT && lw.digit == LD_JUMP)
        begin
            // empty condition mask means unconditional
            taken = (lw.file == 4'h0) || |(lw.file & flags);
            if (taken)
            begin
                next_pc = lw.emit;
            end
        end
        else if (ir_fmt == MPS_FMT_EXEC && ir[11:10] == XK_TRUNC4)
        begin
            next_pc = {pc[PC_W-1:TRUNC4_W], ir[TRUNC4_W-1:0]};
        end
        else if (ir_fmt == MPS_FMT_EXEC && ir[11:10] == XK_TRUNC6)
        begin
            // page bits are never touched, so a six bit jump never leaves the page
            next_pc = {pc[PC_W-1:TRUNC6_W], ir[TRUNC6_W-1:0]};
        end
    end

    always_comb
    begin
        file_we = 1'b0;
        flags_we = 1'b0;
        if (state == MPS_ST_RUN && ir_fmt == MPS_FMT_OPR)
        begin
            file_we = !opw.inhibit;
            flags_we = 1'b1;
        end
        else if (state == MPS_ST_RUN && ir_fmt == MPS_FMT_LIT)
        begin
            file_we = lw.digit == LD_FILE || lw.digit == LD_ADD || lw.digit == LD_AND;
            flags_we = lw.digit == LD_ADD || lw.digit == LD_AND;
        end
    end

    mps_file_mem u_file (
        .clk_i(clk_i),
        .we_i(file_we),
        .waddr_i(ir[11:8]),
        .wdata_i((ir_fmt == MPS_FMT_LIT && lw.digit == LD_FILE) ? lw.emit : alu_y),
        .raddr_i(file_raddr),
        .rdata_o(file_rdata)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= MPS_ST_FETCH;
            pc <= PC_RESET;
            ir <= 16'h0000;
            ir_fmt <= MPS_FMT_EXEC;
        end
        else
        begin
            case (state)
                MPS_ST_FETCH:
                begin
                    if (run)
                    begin
                        ir <= fetched;
                        ir_fmt <= fetched_fmt;
                        state <= MPS_ST_RUN;
                    end
                end
                MPS_ST_RUN:
                begin
                    pc <= next_pc;
                    state <= MPS_ST_FETCH;
                end
                default: state <= MPS_ST_FETCH;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= '0;
        end
        else if (flags_we)
        begin
            flags.c <= alu_c;
            flags.v <= alu_v;
            flags.g <= !alu_y[7] && (alu_y != 8'h00);
            flags.l <= alu_y[7];
        end
    end

    // control and working registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_reg <= 8'h00;
            func_reg <= 8'h00;
            index_reg <= 8'h00;
        end
        else if (state == MPS_ST_RUN && ir_fmt == MPS_FMT_LIT)
        begin
            case (lw.digit)
                LD_SRC: src_reg <= lw.emit;
                LD_FUNC: func_reg <= lw.emit;
                LD_INDEX: index_reg <= lw.emit;
                default: ;
            endcase
        end
        else if (state == MPS_ST_RUN && ir_fmt == MPS_FMT_OPR)
        begin
            case (opw.route)
                RT_FUNC: func_reg <= alu_y;
                RT_INDEX: index_reg <= alu_y;
                RT_SRC: src_reg <= alu_y;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // datapath outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_o <= 8'h00;
            emit_o <= 8'h00;
            result_o <= 8'h00;
        end
        else if (state == MPS_ST_RUN)
        begin
            gate_o <= (ir_fmt == MPS_FMT_OPR) ? onehot3(opw.op) : 8'h00;
            emit_o <= (ir_fmt == MPS_FMT_LIT) ? lw.emit : emit_o;
            result_o <= alu_y;
        end
        else
        begin
            gate_o <= 8'h00;
        end
    end

    assign cs_addr_o = pc;
    assign func_o = func_reg;

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    logic apb_wr;

    assign apb_wr = psel_i && penable_i && pwrite_i && pready_o;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run <= CTRL_RUN_RESET;
        end
        else if (apb_wr && paddr_i == REG_CTRL)
        begin
            run <= pwdata_i[CTRL_RUN_BIT];
        end
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i && !penable_i)
            begin
                case (paddr_i)
                    REG_CTRL: prdata_o <= {31'h0, run};
                    REG_STATUS: prdata_o <= {16'h0, 1'b0, ir_fmt, flags, pc};
                    REG_CREGS: prdata_o <= {8'h0, src_reg, index_reg, func_reg};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

endmodule

// ### tb/mps_cs_model.sv
`timescale 1ns/100ps
module mps_cs_model
    import mps_pkg::*;
(
    input wire logic [PC_W-1:0] addr_i,
    output logic [MW_W-1:0] data_o
);
    // read-only store, filled by the bench before reset release
    logic [MW_W-1:0] mem [256];

    // combinational read: the word must be there in the cycle its address is shown
    assign data_o = mem[addr_i];
endmodule

// ### tb/mps_sequencer_props.sv
`timescale 1ns/100ps
module mps_sequencer_props
    import mps_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [PC_W-1:0] cs_addr_o,
    input wire logic [MW_W-1:0] cs_data_i,
    input wire logic [7:0] gate_o,
    input wire logic [DW-1:0] emit_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // the pc only moves at the end of a run cycle, so the past word is the one executed
    a_reset_pc: assert property ($rose(arst_n_i) |-> cs_addr_o == PC_RESET)
        else $error("pc not at start address after reset");
    a_step_one: assert property ((cs_addr_o != $past(cs_addr_o)) &&
        ($past(cs_data_i[15:12]) inside {[4'h1:4'h6], [4'h8:4'hf]})
        |-> cs_addr_o == $past(cs_addr_o) + 8'h01)
        else $error("pc did not advance by one");
    a_trunc_four: assert property ((cs_addr_o != $past(cs_addr_o)) &&
        ($past(cs_data_i[15:10]) == 6'h01)
        |-> cs_addr_o == {$past(cs_addr_o[7:4]), $past(cs_data_i[3:0])})
        else $error("four bit target wrong");
    a_trunc_six: assert property ((cs_addr_o != $past(cs_addr_o)) &&
        ($past(cs_data_i[15:10]) == 6'h02)
        |-> cs_addr_o == {$past(cs_addr_o[7:6]), $past(cs_data_i[5:0])})
        else $error("six bit target left the page");
    a_lit_jump: assert property ((cs_addr_o != $past(cs_addr_o)) &&
        ($past(cs_data_i[15:8]) == 8'h70)
        |-> cs_addr_o == $past(cs_data_i[7:0]))
        else $error("unconditional jump missed");

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    a_gate_onehot: assert property ($onehot0(gate_o))
        else $error("gate code not one-hot");
    a_gate_op: assert property ((gate_o != 8'h00) && $past(cs_data_i[15])
        |-> gate_o == (8'h01 << $past(cs_data_i[14:12])))
        else $error("gate does not match operate code");
    a_gate_pulse: assert property ((gate_o != 8'h00) |=> gate_o == 8'h00)
        else $error("gate held longer than one cycle");
    a_emit_src: assert property ($changed(emit_o)
        |-> ($past(cs_data_i[15:12]) inside {[4'h1:4'h7]})
        && (emit_o == $past(cs_data_i[7:0])))
        else $error("emit changed without literal word");
endmodule

bind mps_sequencer mps_sequencer_props u_props (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .cs_addr_o(cs_addr_o),
    .cs_data_i(cs_data_i),
    .gate_o(gate_o),
    .emit_o(emit_o)
);

// ### tb/mps_sequencer_tb.sv
`timescale 1ns/100ps
module mps_sequencer_tb
    import mps_pkg::*;
;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PC_W-1:0] cs_addr;
    logic [MW_W-1:0] cs_data;
    logic [7:0] gate;
    logic [DW-1:0] emit;
    logic [DW-1:0] result;
    logic [DW-1:0] func;
    logic [31:0] q;
    logic e;
    int fails = 0;
    int n_checks = 0;

    always #20 clk_i = ~clk_i;

    mps_sequencer u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cs_addr_o(cs_addr),
        .cs_data_i(cs_data), .gate_o(gate), .emit_o(emit), .result_o(result),
        .func_o(func));
    mps_cs_model u_cs (.addr_i(cs_addr), .data_o(cs_data));

    // ------------------------------------------------------------
    // bus access and checking
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this time step
        @(posedge clk_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // program and tests
    // ------------------------------------------------------------
    initial
    begin
        // unused places hold execute no-ops, so a stray branch keeps counting
        for (int i = 0; i < 256; i++)
            u_cs.mem[i] = 16'h0c00;
        u_cs.mem[8'h00] = 16'h30a5;
        u_cs.mem[8'h01] = 16'h1310;
        u_cs.mem[8'h02] = 16'h83d4;
        u_cs.mem[8'h03] = 16'h83d6;
        u_cs.mem[8'h04] = 16'h7040;
        u_cs.mem[8'h40] = 16'h0805;
        u_cs.mem[8'h45] = 16'h040a;
        u_cs.mem[8'h4a] = 16'h78a0;
        u_cs.mem[8'h4b] = 16'h7290;
        u_cs.mem[8'h90] = 16'h83c6;
        for (int k = 1; k < 8; k++)
            u_cs.mem[8'h90 + k] = 16'h83c2 | (16'(k) << 12);
        // index=3, src=7, file5 built by literal load, add and mask
        u_cs.mem[8'h98] = 16'h4003;
        u_cs.mem[8'h99] = 16'h2007;
        u_cs.mem[8'h9a] = 16'h1530;
        u_cs.mem[8'h9b] = 16'h5503;
        u_cs.mem[8'h9c] = 16'h657f;
        // indexed execute: file3 + src, routed to func
        u_cs.mem[8'h9d] = 16'h0002;
        // self loop that keeps adding file5 and src into result
        u_cs.mem[8'h9e] = 16'h050e;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        apb(1'b0, REG_CTRL, 32'h0, q, e);
        chk(q, 32'h0);
        repeat (10) @(posedge clk_i);
        chk(32'(cs_addr), 32'(PC_RESET));
        apb(1'b1, 8'h0c, 32'h1, q, e);
        chk(32'(e), 32'h1);
        apb(1'b1, REG_CTRL, 32'h1, q, e);
        repeat (120) @(posedge clk_i);
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        chk(q & 32'h70ff, 32'h109e);
        apb(1'b0, REG_CREGS, 32'h0, q, e);
        chk(q, 32'h0007_0318);
        chk(32'(func), 32'h18);
        chk(32'(emit), 32'h7f);
        chk(32'(result), 32'h3a);
        print_verdict();
    end

    initial
    begin
        #100000;
        fails++;
        print_verdict();
    end
endmodule
